// >>> rtl/pllhc_defines.svh
// register map, field positions and timing counts of the pll holdover and vco calibration block
`ifndef PLLHC_DEFINES_SVH
`define PLLHC_DEFINES_SVH
`define PLLHC_OFS_LOCKCAL  12'h018
`define PLLHC_OFS_LDSEL    12'h01A
`define PLLHC_OFS_REFCTL   12'h01C
`define PLLHC_OFS_HOLD     12'h01D
`define PLLHC_OFS_MON      12'h01F
`define PLLHC_OFS_UPDATE   12'h232
`define PLLHC_BIT_CAL      0
`define PLLHC_BIT_DLD_DIS  3
`define PLLHC_BIT_WIN      4
`define PLLHC_BIT_HEN0     0
`define PLLHC_BIT_EXTHOLD  1
`define PLLHC_BIT_HEN2     2
`define PLLHC_BIT_CMPEN    3
`define PLLHC_BIT_REFSEL   3
`define PLLHC_BIT_DONE     6
`define PLLHC_LD_CURSRC    6'h04
`define PLLHC_CAL_CYCLES   13'h1130
`define PLLHC_WIN_HI       4'h3
`define PLLHC_WIN_LO       4'h1
`define PLLHC_UNLOCK_EXTRA 4'h2
`endif

// >>> rtl/pllhc_pkg.sv
// types of the pll holdover and vco calibration block
package pllhc_pkg;
  typedef enum logic [2:0] {
    PLLHC_CAL_IDLE = 3'b001,
    PLLHC_CAL_RUN  = 3'b010,
    PLLHC_CAL_DONE = 3'b100
  } pllhc_cal_t;
  typedef enum logic [1:0] {
    PLLHC_HO_ARMED = 2'b01,
    PLLHC_HO_WAIT  = 2'b10
  } pllhc_ho_t;
endpackage

// >>> rtl/pllhc_top.sv
// pll holdover, lock detect and vco calibration control with axi4-lite registers
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pllhc_defines.svh"
module pllhc_top (
  input  wire logic        mclk,            // 40 MHz system clock
  input  wire logic        rstn,            // synchronous reset, active low
  input  wire logic [11:0] s_axi_awaddr,    // write address
  input  wire logic        s_axi_awvalid,   // write address valid
  output logic             s_axi_awready,   // write address ready
  input  wire logic [31:0] s_axi_wdata,     // write data
  input  wire logic [3:0]  s_axi_wstrb,     // write byte strobes
  input  wire logic        s_axi_wvalid,    // write data valid
  output logic             s_axi_wready,    // write data ready
  output logic [1:0]       s_axi_bresp,     // write response
  output logic             s_axi_bvalid,    // write response valid
  input  wire logic        s_axi_bready,    // write response ready
  input  wire logic [11:0] s_axi_araddr,    // read address
  input  wire logic        s_axi_arvalid,   // read address valid
  output logic             s_axi_arready,   // read address ready
  output logic [31:0]      s_axi_rdata,     // read data
  output logic [1:0]       s_axi_rresp,     // read response
  output logic             s_axi_rvalid,    // read valid
  input  wire logic        s_axi_rready,    // read ready
  input  wire logic        pfd_ref_evt,     // reference edge at phase detector, one-cycle pulse
  input  wire logic        pfd_fb_evt,      // feedback edge at phase detector, one-cycle pulse
  input  wire logic [3:0]  pfd_phase_err,   // phase error magnitude of the last comparison
  input  wire logic        first_ref_ok,    // first reference above threshold
  input  wire logic        second_ref_ok,   // second reference present
  input  wire logic        lock_pin_level,  // sensed level on the lock indicator pin
  input  wire logic        ref_low_norm,    // reference below normal threshold
  input  wire logic        ref_low_ext,     // reference below extended threshold
  input  wire logic        vco_low,         // vco below threshold
  output logic             cp_hiz,          // charge pump output held in high impedance
  output logic             b_cnt_reset,     // feedback B counter reset pulse
  output logic             dld_out,         // digital lock detector result
  output logic [5:0]       lock_pin_mode,   // applied lock indicator pin mode
  output logic             lock_pin_cursrc, // current-source lock detect mode active
  output logic             out_sync,        // internal output sync during calibration
  output logic             vco_cal_busy,    // vco calibration running, loop opened
  output logic             sel_second_ref   // second reference selected
);
  import pllhc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // shadow and applied registers
  logic [7:0] sh_lockcal_q, sh_lockcal_d, ap_lockcal_q, ap_lockcal_d;
  logic [7:0] sh_ldsel_q, sh_ldsel_d, ap_ldsel_q, ap_ldsel_d;
  logic [7:0] sh_refctl_q, sh_refctl_d, ap_refctl_q, ap_refctl_d;
  logic [7:0] sh_hold_q, sh_hold_d, ap_hold_q, ap_hold_d;
  logic [7:0] sh_mon_q, sh_mon_d, ap_mon_q, ap_mon_d;
  logic       awpend_q, awpend_d, wpend_q, wpend_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [7:0] wbyte_q, wbyte_d;
  logic       bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic       wr_fire, wr_hit, upd_fire, awrdy_q, awrdy_d, wrdy_q, wrdy_d, cursrc_q, cursrc_d;
  logic       cal_done_q, cal_done_d;

  assign wr_fire  = awpend_q && wpend_q && !bvalid_q;
  assign upd_fire = wr_fire && awaddr_q == `PLLHC_OFS_UPDATE && wbyte_q[0];

  always_comb begin
    awpend_d = awpend_q;
    wpend_d  = wpend_q;
    awaddr_d = awaddr_q;
    wbyte_d  = wbyte_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    sh_lockcal_d = sh_lockcal_q;
    sh_ldsel_d   = sh_ldsel_q;
    sh_refctl_d  = sh_refctl_q;
    sh_hold_d    = sh_hold_q;
    sh_mon_d     = sh_mon_q;
    ap_lockcal_d = ap_lockcal_q;
    ap_ldsel_d   = ap_ldsel_q;
    ap_refctl_d  = ap_refctl_q;
    ap_hold_d    = ap_hold_q;
    ap_mon_d     = ap_mon_q;
    wr_hit = 1'b1;
    if (s_axi_awvalid && !awpend_q) begin
      awpend_d = 1'b1;
      // registers sit at four times their index; the index is what gets decoded
      awaddr_d = {2'b00, s_axi_awaddr[11:2]};
    end
    if (s_axi_wvalid && !wpend_q) begin
      wpend_d = 1'b1;
      wbyte_d = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
    end
    if (wr_fire) begin
      awpend_d = 1'b0;
      wpend_d  = 1'b0;
      bvalid_d = 1'b1;
      case (awaddr_q)
        `PLLHC_OFS_LOCKCAL: sh_lockcal_d = wbyte_q;
        `PLLHC_OFS_LDSEL:   sh_ldsel_d   = {2'b00, wbyte_q[5:0]};
        `PLLHC_OFS_REFCTL:  sh_refctl_d  = {3'b000, wbyte_q[4:0]};
        `PLLHC_OFS_HOLD:    sh_hold_d    = {4'h0, wbyte_q[3:0]};
        `PLLHC_OFS_MON:     sh_mon_d     = {8'h00 | {7'h00, wbyte_q[0]}};
        `PLLHC_OFS_UPDATE:  wr_hit = 1'b1;
        default:            wr_hit = 1'b0;
      endcase
      bresp_d = wr_hit ? 2'b00 : 2'b10;
    end
    if (upd_fire) begin
      ap_lockcal_d = sh_lockcal_q;
      ap_ldsel_d   = sh_ldsel_q;
      ap_refctl_d  = sh_refctl_q;
      ap_hold_d    = sh_hold_q;
      ap_mon_d     = sh_mon_q;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    awrdy_d  = !awpend_d;
    wrdy_d   = !wpend_d;
    cursrc_d = ap_ldsel_d[5:0] == `PLLHC_LD_CURSRC;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      awpend_q <= 1'b0;
      awrdy_q  <= 1'b1;
      wrdy_q   <= 1'b1;
      cursrc_q <= 1'b0;
      wpend_q  <= 1'b0;
      awaddr_q <= 12'h000;
      wbyte_q  <= 8'h00;
      bvalid_q <= 1'b0;
      bresp_q  <= 2'b00;
      sh_lockcal_q <= 8'h00;
      sh_ldsel_q   <= 8'h00;
      sh_refctl_q  <= 8'h00;
      sh_hold_q    <= 8'h00;
      sh_mon_q     <= 8'h00;
      ap_lockcal_q <= 8'h00;
      ap_ldsel_q   <= 8'h00;
      ap_refctl_q  <= 8'h00;
      ap_hold_q    <= 8'h00;
      ap_mon_q     <= 8'h00;
    end else begin
      awpend_q <= awpend_d;
      awrdy_q  <= awrdy_d;
      wrdy_q   <= wrdy_d;
      cursrc_q <= cursrc_d;
      wpend_q  <= wpend_d;
      awaddr_q <= awaddr_d;
      wbyte_q  <= wbyte_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      sh_lockcal_q <= sh_lockcal_d;
      sh_ldsel_q   <= sh_ldsel_d;
      sh_refctl_q  <= sh_refctl_d;
      sh_hold_q    <= sh_hold_d;
      sh_mon_q     <= sh_mon_d;
      ap_lockcal_q <= ap_lockcal_d;
      ap_ldsel_q   <= ap_ldsel_d;
      ap_refctl_q  <= ap_refctl_d;
      ap_hold_q    <= ap_hold_d;
      ap_mon_q     <= ap_mon_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel; reads return shadow values so software sees what it wrote
  logic ref_low_sel, mon_ref_flag, mon_vco_flag, arrdy_q, arrdy_d;
  assign ref_low_sel = ap_mon_q[0] ? ref_low_ext : ref_low_norm;

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d  = 2'b00;
      case ({2'b00, s_axi_araddr[11:2]})
        `PLLHC_OFS_LOCKCAL: rdata_d = {24'h000000, sh_lockcal_q};
        `PLLHC_OFS_LDSEL:   rdata_d = {24'h000000, sh_ldsel_q};
        `PLLHC_OFS_REFCTL:  rdata_d = {24'h000000, sh_refctl_q};
        `PLLHC_OFS_HOLD:    rdata_d = {24'h000000, sh_hold_q};
        `PLLHC_OFS_MON:     rdata_d = {24'h000000, 1'b0, cal_done_q, 2'b00,
                                       dld_out, mon_vco_flag, mon_ref_flag, sh_mon_q[0]};
        `PLLHC_OFS_UPDATE:  rdata_d = 32'h00000000;
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = 2'b10;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    arrdy_d = !rvalid_d;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rvalid_q <= 1'b0;
      arrdy_q  <= 1'b1;
      rdata_q  <= 32'h00000000;
      rresp_q  <= 2'b00;
    end else begin
      rvalid_q <= rvalid_d;
      arrdy_q  <= arrdy_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  assign s_axi_awready = awrdy_q;
  assign s_axi_wready  = wrdy_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arrdy_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // digital lock detector, monitors and reference selection
  logic [3:0] lock_cnt_q, lock_cnt_d, lock_need, win;
  logic       dld_q, dld_d, mon_ref_q, mon_ref_d, mon_vco_q, mon_vco_d, refsel_q, refsel_d;
  logic       cur_ref_ok;

  always_comb begin
    case (ap_lockcal_q[6:5])
      2'b00:   lock_need = 4'h5;
      2'b01:   lock_need = 4'h4;
      2'b10:   lock_need = 4'h8;
      default: lock_need = 4'hF;
    endcase
    win = ap_lockcal_q[`PLLHC_BIT_WIN] ? `PLLHC_WIN_LO : `PLLHC_WIN_HI;
    lock_cnt_d = lock_cnt_q;
    dld_d      = dld_q;
    if (ap_lockcal_q[`PLLHC_BIT_DLD_DIS]) begin
      lock_cnt_d = 4'h0;
      dld_d      = 1'b0;
    end else if (pfd_ref_evt) begin
      if (pfd_phase_err <= win) begin
        if (lock_cnt_q + 4'h1 >= lock_need) begin
          dld_d = 1'b1;
        end else begin
          lock_cnt_d = lock_cnt_q + 4'h1;
        end
      end else begin
        lock_cnt_d = 4'h0;
        if (pfd_phase_err > win + `PLLHC_UNLOCK_EXTRA) begin
          dld_d = 1'b0;
        end
      end
    end
    // automatic switchover prefers the chosen reference and leaves it only when it fails
    refsel_d = ap_refctl_q[`PLLHC_BIT_REFSEL];
    if (ap_refctl_q[4] && (ap_refctl_q[2:1] == 2'b11)) begin
      refsel_d = ap_refctl_q[`PLLHC_BIT_REFSEL] ? second_ref_ok : !first_ref_ok;
    end
    mon_ref_d = ref_low_sel;
    mon_vco_d = vco_low;
  end

  assign mon_ref_flag = mon_ref_q;
  assign mon_vco_flag = mon_vco_q;
  assign cur_ref_ok   = refsel_q ? second_ref_ok : first_ref_ok;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      lock_cnt_q <= 4'h0;
      dld_q      <= 1'b0;
      refsel_q   <= 1'b0;
      mon_ref_q  <= 1'b0;
      mon_vco_q  <= 1'b0;
    end else begin
      lock_cnt_q <= lock_cnt_d;
      dld_q      <= dld_d;
      refsel_q   <= refsel_d;
      mon_ref_q  <= mon_ref_d;
      mon_vco_q  <= mon_vco_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // automatic holdover
  pllhc_ho_t  ho_q, ho_d;
  logic       hiz_q, hiz_d, brst_q, brst_d, ld_sense, ho_en, ho_auto;

  assign ld_sense = ap_hold_q[`PLLHC_BIT_CMPEN] ? lock_pin_level : 1'b1;
  assign ho_en    = ap_hold_q[`PLLHC_BIT_HEN0] && ap_hold_q[`PLLHC_BIT_HEN2];
  assign ho_auto  = ho_en && !ap_hold_q[`PLLHC_BIT_EXTHOLD];

  always_comb begin
    ho_d   = ho_q;
    hiz_d  = hiz_q;
    brst_d = 1'b0;
    if (!ho_auto) begin
      hiz_d = 1'b0;
      ho_d  = PLLHC_HO_ARMED;
    end else if (hiz_q) begin
      // only a reference edge of the selected input ends holdover
      if (pfd_ref_evt && cur_ref_ok) begin
        hiz_d  = 1'b0;
        brst_d = 1'b1;
        ho_d   = PLLHC_HO_WAIT;
      end
    end else begin
      case (ho_q)
        PLLHC_HO_ARMED: begin
          if (!ld_sense) begin
            hiz_d = 1'b1;
          end
        end
        PLLHC_HO_WAIT: begin
          if (dld_q && ld_sense) begin
            ho_d = PLLHC_HO_ARMED;
          end
        end
        default: ho_d = PLLHC_HO_ARMED;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ho_q   <= PLLHC_HO_ARMED;
      hiz_q  <= 1'b0;
      brst_q <= 1'b0;
    end else begin
      ho_q   <= ho_d;
      hiz_q  <= hiz_d;
      brst_q <= brst_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vco calibration sequencer, counted on divided phase-detector events
  pllhc_cal_t cal_q, cal_d;
  logic [12:0] cal_cnt_q, cal_cnt_d;
  logic [2:0]  div_cnt_q, div_cnt_d, cal_div;
  logic        calbit_prev_q, calbit_prev_d, cal_tick, run_q, run_d;

  always_comb begin
    case (ap_lockcal_q[2:1])
      2'b00:   cal_div = 3'h2;
      2'b01:   cal_div = 3'h4;
      2'b10:   cal_div = 3'h7;
      default: cal_div = 3'h7;
    endcase
  end
  assign cal_tick = pfd_ref_evt && (div_cnt_q + 3'h1 >= cal_div);

  always_comb begin
    cal_d         = cal_q;
    cal_cnt_d     = cal_cnt_q;
    cal_done_d    = cal_done_q;
    div_cnt_d     = div_cnt_q;
    calbit_prev_d = ap_lockcal_q[`PLLHC_BIT_CAL];
    if (pfd_ref_evt) begin
      div_cnt_d = cal_tick ? 3'h0 : div_cnt_q + 3'h1;
    end
    case (cal_q)
      PLLHC_CAL_IDLE, PLLHC_CAL_DONE: begin
        // only an applied zero-to-one edge starts it; divider changes never do
        if (ap_lockcal_q[`PLLHC_BIT_CAL] && !calbit_prev_q) begin
          cal_d      = PLLHC_CAL_RUN;
          cal_cnt_d  = 13'h0000;
          cal_done_d = 1'b0;
          div_cnt_d  = 3'h0;
        end
      end
      PLLHC_CAL_RUN: begin
        if (cal_tick) begin
          if (cal_cnt_q == `PLLHC_CAL_CYCLES - 13'h0001) begin
            cal_d      = PLLHC_CAL_DONE;
            cal_done_d = 1'b1;
          end else begin
            cal_cnt_d = cal_cnt_q + 13'h0001;
          end
        end
      end
      default: cal_d = PLLHC_CAL_IDLE;
    endcase
    run_d = cal_d == PLLHC_CAL_RUN;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cal_q         <= PLLHC_CAL_IDLE;
      cal_cnt_q     <= 13'h0000;
      cal_done_q    <= 1'b0;
      div_cnt_q     <= 3'h0;
      calbit_prev_q <= 1'b0;
      run_q         <= 1'b0;
    end else begin
      cal_q         <= cal_d;
      cal_cnt_q     <= cal_cnt_d;
      cal_done_q    <= cal_done_d;
      div_cnt_q     <= div_cnt_d;
      calbit_prev_q <= calbit_prev_d;
      run_q         <= run_d;
    end
  end

  assign cp_hiz          = hiz_q;
  assign b_cnt_reset     = brst_q;
  assign dld_out         = dld_q;
  assign lock_pin_mode   = ap_ldsel_q[5:0];
  assign lock_pin_cursrc = cursrc_q;
  assign out_sync        = run_q;
  assign vco_cal_busy    = run_q;
  assign sel_second_ref  = refsel_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_hiz_entry;
    @(posedge mclk) disable iff (!rstn)
      (ho_auto && !hiz_q && ho_q == PLLHC_HO_ARMED && !ld_sense) |=> hiz_q;
  endproperty
  a_hiz_entry: assert property (p_hiz_entry) else $error("no holdover on lock loss");

  property p_hiz_hold;
    @(posedge mclk) disable iff (!rstn)
      (hiz_q && ho_auto && !(pfd_ref_evt && cur_ref_ok)) |=> hiz_q;
  endproperty
  a_hiz_hold: assert property (p_hiz_hold) else $error("holdover left without reference");

  property p_brst;
    @(posedge mclk) disable iff (!rstn)
      ($fell(hiz_q) && ho_auto) |-> brst_q;
  endproperty
  a_brst: assert property (p_brst) else $error("B counter not reset on release");

  property p_noreentry;
    @(posedge mclk) disable iff (!rstn)
      (ho_q == PLLHC_HO_WAIT) |=> !$rose(hiz_q);
  endproperty
  a_noreentry: assert property (p_noreentry) else $error("holdover reentered before relock");

  property p_disabled;
    @(posedge mclk) disable iff (!rstn)
      !ho_en |=> !hiz_q;
  endproperty
  a_disabled: assert property (p_disabled) else $error("holdover active while disabled");

  property p_done_low;
    @(posedge mclk) disable iff (!rstn)
      (cal_q == PLLHC_CAL_RUN) |-> !cal_done_q && out_sync;
  endproperty
  a_done_low: assert property (p_done_low) else $error("done or sync wrong during calibration");

  property p_cal_start;
    @(posedge mclk) disable iff (!rstn)
      $rose(cal_q == PLLHC_CAL_RUN) |-> $past(ap_lockcal_q[0]) && !$past(calbit_prev_q);
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration started on its own");

  property p_cal_len;
    @(posedge mclk) disable iff (!rstn)
      (cal_q == PLLHC_CAL_RUN && cal_tick && cal_cnt_q == 13'd4399) |=> cal_done_q;
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");

endmodule
`default_nettype wire

// >>> tb/pllhc_bench.sv
// self-checking bench of the pll holdover and vco calibration block
`timescale 1ns/1ps
`default_nettype none
`include "pllhc_defines.svh"
module pll_holdover_vco_calibration_bench;
  import pllhc_pkg::*;
  logic        mclk    = 1'b0;
  logic        rstn    = 1'b0;
  logic [11:0] awaddr  = 12'h000;
  logic [11:0] araddr  = 12'h000;
  logic [31:0] wdata   = 32'h0000_0000;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [3:0]  pherr   = 4'h0;
  logic        ref_evt = 1'b0;
  logic        first_reference_ok = 1'b1;
  logic        second_reference_ok = 1'b1;
  logic        low_e   = 1'b0;
  logic        pin     = 1'b1;
  logic        low_n   = 1'b0;
  logic        vlow    = 1'b0;
  wire logic   awready, wready, bvalid, arready, rvalid;
  wire logic   cp_hiz, b_rst, digital_lock_detector, cursrc, osync, busy, sel2;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [5:0]  pmode;
  int          errors = 0;
  int          checks = 0;
  int          dv;
  logic [15:0] lf = 16'h0010;
  logic [31:0] rv;
  logic [1:0]  rs;

  always #12.5 mclk = ~mclk;

  pllhc_top dut (
    .mclk(mclk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pfd_ref_evt(ref_evt), .pfd_fb_evt(1'b0),
    .pfd_phase_err(pherr), .first_ref_ok(first_reference_ok), .second_ref_ok(second_reference_ok), .lock_pin_level(pin),
    .ref_low_norm(low_n), .ref_low_ext(low_e), .vco_low(vlow), .cp_hiz(cp_hiz), .b_cnt_reset(b_rst),
    .dld_out(digital_lock_detector), .lock_pin_mode(pmode), .lock_pin_cursrc(cursrc), .out_sync(osync),
    .vco_cal_busy(busy), .sel_second_ref(sel2)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // register index to byte address: one word per register
  task automatic wr(input logic [11:0] idx, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    awaddr  <= {idx[9:0], 2'b00};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr  <= {idx[9:0], 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic upd;
    logic [1:0] r;
    wr(`PLLHC_OFS_UPDATE, 32'h0000_0001, r);
  endtask

  // one-cycle reference event every second clock
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge mclk);
      ref_evt <= 1'b1;
      @(posedge mclk);
      ref_evt <= 1'b0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      wr(`PLLHC_OFS_LOCKCAL, {lf, lf} & 32'hFFFF_FFFE, rs);
      rd(`PLLHC_OFS_LOCKCAL, rv, rs);
      chk(rv, {24'h00_0000, lf[7:1], 1'b0});
    end
    wr(`PLLHC_OFS_LOCKCAL, 32'h0000_0000, rs);
    rd(12'h019, rv, rs);
    chk(rs, 2'b10);
    wr(`PLLHC_OFS_LDSEL, 32'h0000_0004, rs);
    repeat (2) @(posedge mclk);
    chk(cursrc, 1'b0);
    upd();
    repeat (2) @(posedge mclk);
    chk({cursrc, pmode}, 7'h44);
    vlow  <= 1'b1;
    low_n <= 1'b1;
    rd(`PLLHC_OFS_MON, rv, rs);
    chk(rv & 32'h0000_0006, 32'h0000_0006);
    wr(`PLLHC_OFS_MON, 32'h0000_0001, rs);
    upd();
    low_n <= 1'b0;
    low_e <= 1'b1;
    rd(`PLLHC_OFS_MON, rv, rs);
    chk(rv[1:0], 2'b11);
    low_n <= 1'b1;
    low_e <= 1'b0;
    rd(`PLLHC_OFS_MON, rv, rs);
    chk(rv[1:0], 2'b01);
    $display("test registers done");
    // lock needs exactly five in-window comparisons at code 00
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      pherr <= 4'(lf % 3);
      pulse(1);
    end
    repeat (3) @(posedge mclk);
    chk(digital_lock_detector, 1'b0);
    pulse(1);
    repeat (3) @(posedge mclk);
    chk(digital_lock_detector, 1'b1);
    // just past the lock window but inside the unlock margin keeps lock
    pherr <= 4'h5;
    pulse(1);
    repeat (3) @(posedge mclk);
    chk(digital_lock_detector, 1'b1);
    pherr <= 4'h6;
    pulse(1);
    repeat (3) @(posedge mclk);
    chk(digital_lock_detector, 1'b0);
    $display("test lock detect done");
    for (int c = 0; c < 2; c++) begin
      dv = 2 << c;
      wr(`PLLHC_OFS_LOCKCAL, 32'(c * 2 + 1), rs);
      repeat (3) @(posedge mclk);
      chk(busy, 1'b0);
      upd();
      repeat (2) @(posedge mclk);
      chk({busy, osync}, 2'b11);
      rd(`PLLHC_OFS_MON, rv, rs);
      chk(rv[6], 1'b0);
      pulse(4400 * dv - dv - 1);
      chk(busy, 1'b1);
      pulse(2 * dv + 1);
      repeat (3) @(posedge mclk);
      chk({busy, osync}, 2'b00);
      rd(`PLLHC_OFS_MON, rv, rs);
      chk(rv[6], 1'b1);
      // bit left at one: a second update is no new request
      upd();
      repeat (3) @(posedge mclk);
      chk(busy, 1'b0);
      wr(`PLLHC_OFS_LOCKCAL, 32'h0000_0000, rs);
      upd();
      $display("test calibration done");
    end
    pin     <= 1'b0;
    first_reference_ok <= 1'b0;
    repeat (5) @(posedge mclk);
    chk(cp_hiz, 1'b0);
    // one enable missing, comparator off, external control: none may tristate
    for (int h = 0; h < 3; h++) begin
      wr(`PLLHC_OFS_HOLD, 32'(h == 0 ? 9 : h == 1 ? 5 : 15), rs);
      upd();
      repeat (3) @(posedge mclk);
      chk(cp_hiz, 1'b0);
    end
    wr(`PLLHC_OFS_HOLD, 32'h0000_000D, rs);
    upd();
    repeat (3) @(posedge mclk);
    chk(cp_hiz, 1'b1);
    pulse(10);
    chk(cp_hiz, 1'b1);
    first_reference_ok <= 1'b1;
    pulse(1);
    rv = 32'h0000_0000;
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      if (b_rst === 1'b1) rv = {30'h0, cp_hiz, b_rst};
    end
    chk(rv, 32'h0000_0001);
    repeat (10) @(posedge mclk);
    chk(cp_hiz, 1'b0);
    $display("test holdover done");
    wr(`PLLHC_OFS_REFCTL, 32'h0000_0016, rs);
    upd();
    first_reference_ok <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(sel2, 1'b1);
    wr(`PLLHC_OFS_REFCTL, 32'h0000_001E, rs);
    upd();
    first_reference_ok <= 1'b1;
    second_reference_ok <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(sel2, 1'b0);
    $display("test reference select done");
    summarize();
  end

  // the run needs about 53000 cycles
  initial begin
    repeat (80000) @(posedge mclk);
    errors++;
    summarize();
  end
endmodule
`default_nettype wire
